// ===== common/nfm_cfg.svh
// constants for the operation, mode and bit-rate register bank
`ifndef NFM_CFG_SVH
`define NFM_CFG_SVH
`define NFM_ADDR_OPCTL 8'h08
`define NFM_ADDR_MODE 8'h0C
`define NFM_ADDR_RATE 8'h10
`define NFM_ADDR_NORMRATE 8'h14
`define NFM_ADDR_STATUS 8'h18
`define NFM_IDX_OPCTL 8'h02
`define NFM_IDX_MODE 8'h03
`define NFM_IDX_RATE 8'h04
`define NFM_OPCTL_RESET 8'h00
`define NFM_MODE_RESET 8'h08
`define NFM_RATE_RESET 8'h00
`define NFM_NORMRATE_RESET 8'h00
`define NFM_OPCTL_MASK 8'hFC
`define NFM_MODE_MASK 8'hF9
`define NFM_RATE_MASK 8'hFF
`define NFM_BIT_READY 7
`define NFM_BIT_RXEN 6
`define NFM_BIT_RXONECH 5
`define NFM_BIT_RXMAN 4
`define NFM_BIT_TXEN 3
`define NFM_BIT_WAKEUP 2
`define NFM_BIT_TARGET 7
`define NFM_BIT_AUTORCA 0
`define NFM_OPMODE_HI 6
`define NFM_OPMODE_LO 3
`define NFM_TXRATE_HI 7
`define NFM_TXRATE_LO 4
`define NFM_RXRATE_HI 3
`define NFM_RXRATE_LO 0
`define NFM_VHR_FIRST 4'h4
`define NFM_VHR_RX_LAST 4'h5
`define NFM_RATE_LAST 4'h6
`endif

// ===== common/nfm_pkg.sv
// types for the operation, mode and bit-rate register bank
package nfm_pkg;
  typedef enum logic [3:0] {
    NFM_OM_PEER = 4'h0,
    NFM_OM_TYPEA = 4'h1,
    NFM_OM_TYPEB = 4'h2,
    NFM_OM_CARD3 = 4'h3,
    NFM_OM_TYPE1 = 4'h4,
    NFM_OM_SUBC = 4'hE,
    NFM_OM_BPSK = 4'hF
  } nfm_opmode_t;

  typedef enum logic [2:0] {
    NFM_P_INIT_PEER = 3'b000,
    NFM_P_INIT_CARD = 3'b001,
    NFM_P_INIT_STREAM = 3'b010,
    NFM_P_TARG_DETECT = 3'b011,
    NFM_P_TARG_NORMAL = 3'b100,
    NFM_P_NONE = 3'b111
  } nfm_proto_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } nfm_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } nfm_apb_rsp_t;

  typedef struct packed {
    logic fieldOnCmd;
    logic transmitDone;
    logic setDefaultCmd;
    logic goNormalCmd;
    logic extFieldOff;
  } nfm_event_t;

  typedef struct packed {
    logic readyMode;
    logic rxEnable;
    logic rxOneChannel;
    logic rxManualSel;
    logic txEnable;
    logic wakeupEnable;
    logic targetRole;
    logic [3:0] opMode;
    logic [3:0] transmitRateCode;
    logic [3:0] receiveRateCode;
    logic rxRateUsed;
    logic veryHighRate;
    logic startCollisionAvoid;
    logic modeValid;
    logic rateValid;
  } nfm_ctrl_t;

  typedef struct packed {
    logic [7:0] opctl;
    logic [7:0] mode;
    logic [7:0] rate;
    logic [7:0] normRate;
    logic [31:0] prdata;
    logic pslverr;
    logic caPulse;
  } nfm_state_t;
endpackage : nfm_pkg

// ===== hdl/nfm_regs.sv
// operation control, mode definition and bit-rate register bank, APB slave
`timescale 1ns/10ps
`include "nfm_cfg.svh"
module nfm_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire nfm_pkg::nfm_apb_req_t apbReq,
  output nfm_pkg::nfm_apb_rsp_t apbRsp,
  input wire nfm_pkg::nfm_event_t evt,
  output nfm_pkg::nfm_ctrl_t ctrl
);
  import nfm_pkg::*;

  nfm_state_t st;
  nfm_state_t next_st;
  logic answerNow;
  logic acc;
  logic wr;
  logic roleCodeOk;
  logic txRateOk;
  logic rxRateOk;
  logic splitRates;
  logic outValid;
  logic [3:0] om;
  logic [3:0] txr;
  logic [3:0] rxr;
  nfm_proto_t proto;

  // only the first access cycle is taken, so an event in the wait
  // cycle is not overwritten by a second copy of the same write
  assign acc = apbReq.psel & apbReq.penable & ~answerNow;
  assign wr = acc & apbReq.pwrite;
  assign om = st.mode[`NFM_OPMODE_HI:`NFM_OPMODE_LO];
  assign txr = st.rate[`NFM_TXRATE_HI:`NFM_TXRATE_LO];
  assign rxr = st.rate[`NFM_RXRATE_HI:`NFM_RXRATE_LO];

  // protocol class from role and op-mode code
  always_comb begin
    proto = NFM_P_NONE;
    if (st.mode[`NFM_BIT_TARGET]) begin
      case (om)
        4'h0: proto = NFM_P_TARG_DETECT;
        4'h1: proto = NFM_P_TARG_NORMAL;
        default: proto = NFM_P_NONE;
      endcase
    end else begin
      case (om)
        NFM_OM_PEER: proto = NFM_P_INIT_PEER;
        NFM_OM_TYPEA, NFM_OM_TYPEB, NFM_OM_CARD3,
        NFM_OM_TYPE1: proto = NFM_P_INIT_CARD;
        NFM_OM_SUBC, NFM_OM_BPSK: proto = NFM_P_INIT_STREAM;
        default: proto = NFM_P_NONE;
      endcase
    end
  end

  assign roleCodeOk = (proto != NFM_P_NONE);
  // peer modes run one shared rate; card and stream modes may split
  assign splitRates = (proto == NFM_P_INIT_CARD)
    || (proto == NFM_P_INIT_STREAM);
  // very high transmit rate only with type B
  assign txRateOk = (txr <= `NFM_RATE_LAST)
    && ((txr < `NFM_VHR_FIRST) || (!st.mode[`NFM_BIT_TARGET]
    && om == NFM_OM_TYPEB));
  // very high receive rates: only /8 and /4
  assign rxRateOk = !splitRates || ((rxr <= `NFM_RATE_LAST)
    && (rxr <= `NFM_VHR_RX_LAST));
  assign outValid = roleCodeOk && txRateOk && rxRateOk;

  always_comb begin
    next_st = st;
    next_st.caPulse = 1'b0;
    next_st.pslverr = 1'b0;
    if (acc && !apbReq.pwrite) begin
      next_st.prdata = 32'h0000_0000;
      case (apbReq.paddr)
        `NFM_ADDR_OPCTL: next_st.prdata[7:0] = st.opctl;
        `NFM_ADDR_MODE: next_st.prdata[7:0] = st.mode;
        `NFM_ADDR_RATE: next_st.prdata[7:0] = st.rate;
        `NFM_ADDR_NORMRATE: next_st.prdata[7:0] = st.normRate;
        `NFM_ADDR_STATUS:
          next_st.prdata[2:0] = {rxRateOk & txRateOk, roleCodeOk, outValid};
        default: next_st.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      case (apbReq.paddr)
        `NFM_ADDR_OPCTL:
          next_st.opctl = apbReq.pwdata[7:0] & `NFM_OPCTL_MASK;
        `NFM_ADDR_MODE:
          next_st.mode = apbReq.pwdata[7:0] & `NFM_MODE_MASK;
        `NFM_ADDR_RATE:
          next_st.rate = apbReq.pwdata[7:0] & `NFM_RATE_MASK;
        `NFM_ADDR_NORMRATE:
          next_st.normRate = apbReq.pwdata[7:0] & `NFM_RATE_MASK;
        `NFM_ADDR_STATUS: next_st.pslverr = 1'b0;
        default: next_st.pslverr = 1'b1;
      endcase
    end
    // hardware events come after bus writes so they win the same cycle
    if (evt.transmitDone && (proto == NFM_P_INIT_PEER
        || proto == NFM_P_TARG_DETECT || proto == NFM_P_TARG_NORMAL)) begin
      next_st.opctl[`NFM_BIT_TXEN] = 1'b0;
    end
    if (evt.fieldOnCmd) begin
      next_st.opctl[`NFM_BIT_TXEN] = 1'b1;
    end
    // set-default leaves operation control alone
    if (evt.setDefaultCmd) begin
      next_st.mode = `NFM_MODE_RESET;
      next_st.rate = `NFM_RATE_RESET;
    end
    if (evt.goNormalCmd) begin
      next_st.rate = st.normRate;
    end
    next_st.caPulse = evt.extFieldOff
      & st.mode[`NFM_BIT_AUTORCA];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st.opctl <= `NFM_OPCTL_RESET;
      st.mode <= `NFM_MODE_RESET;
      st.rate <= `NFM_RATE_RESET;
      st.normRate <= `NFM_NORMRATE_RESET;
      st.prdata <= 32'h0000_0000;
      st.pslverr <= 1'b0;
      st.caPulse <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // one-wait slave: data registered at the edge that ends the first access
  // cycle, so prdata is captured in the first access cycle; answer is
  // given in the second access cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      answerNow <= 1'b0;
    end else begin
      answerNow <= acc & ~answerNow;
    end
  end

  assign apbRsp.pready = answerNow;
  assign apbRsp.prdata = st.prdata;
  assign apbRsp.pslverr = st.pslverr;

  always_comb begin
    ctrl.readyMode = st.opctl[`NFM_BIT_READY];
    ctrl.rxEnable = st.opctl[`NFM_BIT_RXEN] & outValid;
    ctrl.rxOneChannel = st.opctl[`NFM_BIT_RXONECH];
    ctrl.rxManualSel = st.opctl[`NFM_BIT_RXMAN]
      & ~st.opctl[`NFM_BIT_RXONECH];
    ctrl.txEnable = st.opctl[`NFM_BIT_TXEN] & outValid;
    ctrl.wakeupEnable = st.opctl[`NFM_BIT_WAKEUP];
    ctrl.targetRole = st.mode[`NFM_BIT_TARGET];
    ctrl.opMode = om;
    ctrl.transmitRateCode = txr;
    ctrl.receiveRateCode = splitRates ? rxr : txr;
    ctrl.rxRateUsed = splitRates;
    ctrl.veryHighRate = (txr >= `NFM_VHR_FIRST)
      || (splitRates && rxr >= `NFM_VHR_FIRST);
    ctrl.startCollisionAvoid = st.caPulse;
    ctrl.modeValid = roleCodeOk;
    ctrl.rateValid = txRateOk & rxRateOk;
  end
endmodule : nfm_regs

// ===== dv/nfm_regs_props.sv
// assertion checker for the operation, mode and bit-rate register bank
`timescale 1ns/10ps
module nfm_regs_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire nfm_pkg::nfm_apb_req_t apbReq,
  input wire nfm_pkg::nfm_apb_rsp_t apbRsp,
  input wire nfm_pkg::nfm_event_t evt,
  input wire nfm_pkg::nfm_ctrl_t ctrl
);
  import nfm_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic opWr;
  // first access cycle of a write to operation control
  assign opWr = apbReq.psel && apbReq.penable && apbReq.pwrite &&
    !apbRsp.pready && apbReq.paddr == 8'h08;
  AST_READY_WRITE: assert property (opWr |=>
    ctrl.readyMode == $past(apbReq.pwdata[7])) else $error("ready bit");
  AST_MODE_GATE: assert property (!ctrl.modeValid |->
    !ctrl.txEnable && !ctrl.rxEnable) else $error("bad mode not gated");
  AST_RATE_GATE: assert property (!ctrl.rateValid |->
    !ctrl.txEnable && !ctrl.rxEnable) else $error("bad rate not gated");
  AST_MODE_DECODE: assert property (
    ctrl.modeValid == (ctrl.targetRole ? ctrl.opMode < 4'h2 :
    (ctrl.opMode < 4'h5 || ctrl.opMode > 4'hD))) else $error("mode decode");
  AST_RATE_DECODE: assert property (
    (ctrl.transmitRateCode > 4'h6 ||
    (ctrl.transmitRateCode > 4'h3 && (ctrl.targetRole ||
    ctrl.opMode != 4'h2))) |-> !ctrl.rateValid) else $error("rate decode");
  AST_FIELD_ON: assert property (
    evt.fieldOnCmd && !evt.transmitDone |=>
    ctrl.txEnable || !(ctrl.modeValid && ctrl.rateValid))
    else $error("field-on left tx off");
  AST_SET_DEFAULT: assert property (evt.setDefaultCmd &&
    !evt.goNormalCmd |=> ctrl.opMode == 4'h1 && !ctrl.targetRole &&
    ctrl.transmitRateCode == 4'h0) else $error("set-default values");
  AST_KEEP_OPCTL: assert property (
    evt.setDefaultCmd && !apbReq.psel |=>
    $stable(ctrl.readyMode) && $stable(ctrl.wakeupEnable))
    else $error("set-default touched op control");
  AST_AVOID_PULSE: assert property (ctrl.startCollisionAvoid |->
    $past(evt.extFieldOff)) else $error("stray avoidance start");
  AST_ONE_WAIT: assert property ($rose(apbReq.penable) && apbReq.psel |->
    !apbRsp.pready ##1 apbRsp.pready) else $error("wait state");
endmodule : nfm_regs_props

bind nfm_regs nfm_regs_props nfm_regs_props_i (.clk(clk), .sys_rst(sys_rst),
  .apbReq(apbReq), .apbRsp(apbRsp), .evt(evt), .ctrl(ctrl));

// ===== dv/nfm_regs_test.sv
// self-checking bench for the operation, mode and bit-rate register bank
`timescale 1ns/10ps
module nfm_regs_test;
  import nfm_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  nfm_apb_req_t apbReq = '0;
  nfm_apb_rsp_t apbRsp;
  nfm_event_t evt = '0;
  nfm_ctrl_t ctrl;
  int n_fail = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic err;
  nfm_regs nfm_regs_i (.clk(clk), .sys_rst(sys_rst), .apbReq(apbReq),
    .apbRsp(apbRsp), .evt(evt), .ctrl(ctrl));
  always #50 clk = ~clk;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
      i++;
    end while (apbRsp.pready !== 1'b1 && i < 20);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
    // hang guard: a slave that never answers ends the run
    if (i >= 20) begin
      n_fail++;
      finish_test();
    end
    @(negedge clk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic ev(input nfm_event_t e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
    @(negedge clk);
  endtask : ev
  task automatic rt(input logic [7:0] m, input logic [7:0] r, input logic e);
    apb(1'b1, 8'h0C, {24'h0, m});
    apb(1'b1, 8'h10, {24'h0, r});
    chk({ctrl.rateValid, ctrl.txEnable}, {2{e}});
  endtask : rt
  task automatic t_reset;
    rdc(8'h08, 32'h0);
    rdc(8'h0C, 32'h8);
    rdc(8'h10, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'h1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_opctl;
    apb(1'b1, 8'h08, 32'hFF);
    rdc(8'h08, 32'hFC);
    chk({ctrl.readyMode, ctrl.rxEnable, ctrl.rxOneChannel, ctrl.txEnable,
      ctrl.wakeupEnable}, 5'h1F);
    apb(1'b1, 8'h08, 32'h10);
    chk({ctrl.readyMode, ctrl.rxManualSel,
      ctrl.wakeupEnable}, 3'h2);
    apb(1'b1, 8'h0C, 32'hFF);
    rdc(8'h0C, 32'hF9);
    $display("op control test done");
  endtask : t_opctl
  task automatic t_mode;
    logic e;
    apb(1'b1, 8'h08, 32'h48);
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 16; c++) begin
        e = r ? c < 2 : (c < 5 || c > 13);
        apb(1'b1, 8'h0C, {24'h0, r[0], c[3:0], 3'h0});
        chk({ctrl.modeValid, ctrl.txEnable,
          ctrl.rxEnable}, {3{e}});
      end
    end
    $display("mode test done");
  endtask : t_mode
  task automatic t_rate;
    for (int c = 0; c < 16; c++) begin
      rt(8'h10, {c[3:0], 4'h0}, c < 7);
      chk(ctrl.veryHighRate, c > 3);
    end
    rt(8'h08, 8'h40, 1'b0);
    rt(8'h08, 8'h06, 1'b0);
    rt(8'h08, 8'h05, 1'b1);
    chk(ctrl.receiveRateCode, 4'h5);
    chk(ctrl.rxRateUsed, 1'b1);
    rt(8'h00, 8'h21, 1'b1);
    chk(ctrl.receiveRateCode, 4'h2);
    chk(ctrl.rxRateUsed, 1'b0);
    $display("rate test done");
  endtask : t_rate
  task automatic t_events;
    apb(1'b1, 8'h0C, 32'h1);
    apb(1'b1, 8'h08, 32'h0);
    ev(5'h01);
    chk(ctrl.startCollisionAvoid, 1'h1);
    ev(5'h10);
    rdc(8'h08, 32'h8);
    ev(5'h08);
    rdc(8'h08, 32'h0);
    apb(1'b1, 8'h14, 32'h21);
    ev(5'h02);
    rdc(8'h10, 32'h21);
    apb(1'b1, 8'h08, 32'h84);
    ev(5'h04);
    rdc(8'h08, 32'h84);
    rdc(8'h0C, 32'h8);
    rdc(8'h10, 32'h0);
    ev(5'h01);
    chk(ctrl.startCollisionAvoid, 1'h0);
    $display("event test done");
  endtask : t_events
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_opctl();
    t_mode();
    t_rate();
    t_events();
    finish_test();
  end
endmodule : nfm_regs_test
